/* File: common/dac_ctl_pkg.sv */
// Package for the dual converter output control block
`default_nettype none
package daoc_pkg;
	localparam int DAOC_W = 12;
	localparam logic [11:0] DAOC_CODE_MIN = 12'h000;
	localparam logic [11:0] DAOC_CODE_MID = 12'h800;
	localparam logic [11:0] DAOC_CODE_MAX = 12'hFFF;
	localparam int DAOC_MSB = 11;
	// Format select pin levels, coded from the four strap levels
	typedef enum logic [1:0] {
		DAOC_LVL_GND = 2'b00,
		DAOC_LVL_THIRD = 2'b01,
		DAOC_LVL_TWO_THIRD = 2'b10,
		DAOC_LVL_SUPPLY = 2'b11
	} daoc_level_e;
	typedef enum logic [1:0] {
		DAOC_PWR_RUN = 2'b00,
		DAOC_PWR_NAP = 2'b01,
		DAOC_PWR_SLEEP = 2'b10,
		DAOC_PWR_WAKE = 2'b11
	} daoc_pwr_e;
	// Recovery times
	localparam int DAOC_NAP_WAKE_CYC = 100;
	localparam int DAOC_SLEEP_WAKE_US = 2000;
	localparam int DAOC_CLK_MHZ = 50;
	localparam int DAOC_SLEEP_WAKE_CYC = DAOC_SLEEP_WAKE_US * DAOC_CLK_MHZ;
	localparam int DAOC_DCS_LOCK_CYC = 100;
	localparam logic [31:0] DAOC_REG_CTRL = 32'h0000_0000;
	localparam logic [31:0] DAOC_REG_STAT = 32'h0000_0004;
	localparam logic [31:0] DAOC_REG_SAMP = 32'h0000_0008;
	localparam logic [1:0] DAOC_RESP_OK = 2'b00;
	localparam logic [1:0] DAOC_RESP_DEC = 2'b11;
	typedef struct packed {
		logic [11:0] word;
		logic flag;
	} daoc_samp_s;
	typedef struct packed {
		logic [11:0] data;
		logic flag;
		logic en;
	} daoc_bus_s;
endpackage : daoc_pkg
`default_nettype wire

/* File: logic/daoc_chan.sv */
// One converter channel: formatting, power state and output enable
`timescale 1ns/100ps
`default_nettype none
module daoc_chan
	import daoc_pkg::*;
#(
	parameter int WAKE_SLEEP_CYC = DAOC_SLEEP_WAKE_CYC
)
(
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Raw conversion result and range strobes
	input wire logic sample_tick,
	input wire logic [11:0] raw_code,
	input wire logic over_hi,
	input wire logic over_lo,
	// Controls
	input wire logic twos_comp,
	input wire logic dcs_locked,
	input wire logic power_down_in,
	input wire logic output_disable_n,
	// Results
	output daoc_samp_s samp,
	output logic out_en,
	output daoc_pwr_e pwr_state,
	output logic data_valid
);
	localparam int CW = $clog2(DAOC_SLEEP_WAKE_CYC > WAKE_SLEEP_CYC ?
		DAOC_SLEEP_WAKE_CYC + 1 : WAKE_SLEEP_CYC + 1);
	if (WAKE_SLEEP_CYC < 1)
	begin : g_bad_wake
		$error("WAKE_SLEEP_CYC must be at least one");
	end
	daoc_pwr_e next_pwr_state;
	logic [CW-1:0] wait_cnt;
	logic [CW-1:0] next_wait_cnt;
	daoc_samp_s next_samp;
	logic [11:0] ob;
	always_comb
	begin
		next_pwr_state = pwr_state;
		next_wait_cnt = wait_cnt;
		case (pwr_state)
			DAOC_PWR_RUN:
			begin
				if (power_down_in)
					next_pwr_state = output_disable_n ? DAOC_PWR_SLEEP : DAOC_PWR_NAP;
			end
			DAOC_PWR_NAP, DAOC_PWR_SLEEP:
			begin
				if (!power_down_in)
				begin
					next_pwr_state = DAOC_PWR_WAKE;
					next_wait_cnt = (pwr_state == DAOC_PWR_SLEEP) ?
						CW'(WAKE_SLEEP_CYC) : CW'(DAOC_NAP_WAKE_CYC);
				end
				else
					next_pwr_state = output_disable_n ? DAOC_PWR_SLEEP : DAOC_PWR_NAP;
			end
			DAOC_PWR_WAKE:
			begin
				if (power_down_in)
					next_pwr_state = output_disable_n ? DAOC_PWR_SLEEP : DAOC_PWR_NAP;
				else if (wait_cnt <= CW'(1))
				begin
					next_pwr_state = DAOC_PWR_RUN;
					next_wait_cnt = '0;
				end
				else
					next_wait_cnt = wait_cnt - CW'(1);
			end
			default: next_pwr_state = DAOC_PWR_RUN;
		endcase
	end
	always_comb
	begin
		next_samp = samp;
		ob = raw_code;
		if (over_hi)
			ob = DAOC_CODE_MAX;
		else if (over_lo)
			ob = DAOC_CODE_MIN;
		if (sample_tick && pwr_state != DAOC_PWR_NAP && pwr_state != DAOC_PWR_SLEEP)
		begin
			next_samp.word = ob;
			if (twos_comp)
				next_samp.word[DAOC_MSB] = ~ob[DAOC_MSB];
			next_samp.flag = over_hi | over_lo;
		end
	end
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			pwr_state <= DAOC_PWR_RUN;
			wait_cnt <= '0;
			samp <= '0;
		end
		else
		begin
			pwr_state <= next_pwr_state;
			wait_cnt <= next_wait_cnt;
			samp <= next_samp;
		end
	end
	// Outputs float while disabled or powered down
	assign out_en = !output_disable_n && pwr_state != DAOC_PWR_NAP
		&& pwr_state != DAOC_PWR_SLEEP;
	assign data_valid = pwr_state == DAOC_PWR_RUN && dcs_locked;
endmodule : daoc_chan
`default_nettype wire

/* File: logic/daoc_top.sv */
// Dual converter output control: two channels, bus swap, AXI4-Lite status
//
// Decided for this implementation: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/100ps
`default_nettype none
module daoc_top
	import daoc_pkg::*;
#(
	parameter int WAKE_SLEEP_CYC = DAOC_SLEEP_WAKE_CYC,
	parameter int DCS_LOCK_CYC = DAOC_DCS_LOCK_CYC
)
(
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Converter core results, per channel
	input wire logic sample_clock_a,
	input wire logic sample_clock_b,
	input wire logic [11:0] raw_code_a,
	input wire logic [11:0] raw_code_b,
	input wire logic over_hi_a,
	input wire logic over_lo_a,
	input wire logic over_hi_b,
	input wire logic over_lo_b,
	// Strap and control pins
	input wire logic [1:0] format_select,
	input wire logic bus_swap_select,
	input wire logic output_disable_n_a,
	input wire logic output_disable_n_b,
	input wire logic power_down_in_a,
	input wire logic power_down_in_b,
	// Output buses, two signals each pin: value and output enable
	output logic [11:0] bus_a_data,
	output logic [11:0] bus_a_data_oe,
	output logic overrange_flag_a,
	output logic overrange_flag_a_oe,
	output logic [11:0] bus_b_data,
	output logic [11:0] bus_b_data_oe,
	output logic overrange_flag_b,
	output logic overrange_flag_b_oe,
	output logic stabilizer_on,
	// AXI4-Lite slave
	input wire logic [31:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [31:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	localparam int LW = $clog2(DCS_LOCK_CYC + 1);
	if (DCS_LOCK_CYC < 1)
	begin : g_bad_lock
		$error("DCS_LOCK_CYC must be at least one");
	end

	// Software overrides: bit0 forces format, bit1 value, bit2 forces swap, bit3 value
	logic [3:0] ctrl;
	logic [3:0] next_ctrl;
	logic twos_comp;
	logic bus_straight;
	logic clk_a_q;
	logic clk_b_q;
	logic tick_a;
	logic tick_b;
	logic [LW-1:0] lock_cnt;
	logic [LW-1:0] next_lock_cnt;
	logic dcs_locked;
	daoc_samp_s samp_a;
	daoc_samp_s samp_b;
	logic en_a;
	logic en_b;
	daoc_pwr_e pwr_a;
	daoc_pwr_e pwr_b;
	logic valid_a;
	logic valid_b;
	daoc_bus_s next_bus_a;
	daoc_bus_s next_bus_b;
	daoc_bus_s bus_a;
	daoc_bus_s bus_b;

	// One setting for both channels, decoded from the strap level
	always_comb
	begin
		twos_comp = format_select == DAOC_LVL_TWO_THIRD
			|| format_select == DAOC_LVL_SUPPLY;
		if (ctrl[0])
			twos_comp = ctrl[1];
		stabilizer_on = format_select == DAOC_LVL_THIRD
			|| format_select == DAOC_LVL_TWO_THIRD;
		bus_straight = ctrl[2] ? ctrl[3] : bus_swap_select;
	end

	// Rising edge of each sample clock, sampled as a synchronous input
	assign tick_a = sample_clock_a && !clk_a_q;
	assign tick_b = sample_clock_b && !clk_b_q;

	// Stabilizer lock counts rising edges after enable
	always_comb
	begin
		next_lock_cnt = lock_cnt;
		if (!stabilizer_on)
			next_lock_cnt = '0;
		else if (lock_cnt < LW'(DCS_LOCK_CYC) && tick_a)
			next_lock_cnt = lock_cnt + LW'(1);
	end
	assign dcs_locked = !stabilizer_on || lock_cnt == LW'(DCS_LOCK_CYC);

	daoc_chan #(.WAKE_SLEEP_CYC(WAKE_SLEEP_CYC)) u_chan_a (
		.aclk(aclk),
		.aresetn(aresetn),
		.sample_tick(tick_a),
		.raw_code(raw_code_a),
		.over_hi(over_hi_a),
		.over_lo(over_lo_a),
		.twos_comp(twos_comp),
		.dcs_locked(dcs_locked),
		.power_down_in(power_down_in_a),
		.output_disable_n(output_disable_n_a),
		.samp(samp_a),
		.out_en(en_a),
		.pwr_state(pwr_a),
		.data_valid(valid_a)
	);
	daoc_chan #(.WAKE_SLEEP_CYC(WAKE_SLEEP_CYC)) u_chan_b (
		.aclk(aclk),
		.aresetn(aresetn),
		.sample_tick(tick_b),
		.raw_code(raw_code_b),
		.over_hi(over_hi_b),
		.over_lo(over_lo_b),
		.twos_comp(twos_comp),
		.dcs_locked(dcs_locked),
		.power_down_in(power_down_in_b),
		.output_disable_n(output_disable_n_b),
		.samp(samp_b),
		.out_en(en_b),
		.pwr_state(pwr_b),
		.data_valid(valid_b)
	);

	// Bus routing; enables follow the channel that is routed
	always_comb
	begin
		if (bus_straight)
		begin
			next_bus_a = '{data: samp_a.word, flag: samp_a.flag, en: en_a};
			next_bus_b = '{data: samp_b.word, flag: samp_b.flag, en: en_b};
		end
		else
		begin
			next_bus_a = '{data: samp_b.word, flag: samp_b.flag, en: en_b};
			next_bus_b = '{data: samp_a.word, flag: samp_a.flag, en: en_a};
		end
	end

	assign bus_a_data = bus_a.data;
	assign bus_a_data_oe = {DAOC_W{bus_a.en}};
	assign overrange_flag_a = bus_a.flag;
	assign overrange_flag_a_oe = bus_a.en;
	assign bus_b_data = bus_b.data;
	assign bus_b_data_oe = {DAOC_W{bus_b.en}};
	assign overrange_flag_b = bus_b.flag;
	assign overrange_flag_b_oe = bus_b.en;

	// AXI4-Lite: one write and one read at a time, aw and w in either order
	logic aw_held;
	logic next_aw_held;
	logic w_held;
	logic next_w_held;
	logic [31:0] aw_addr;
	logic [31:0] next_aw_addr;
	logic [31:0] w_data;
	logic [31:0] next_w_data;
	logic [3:0] w_strb;
	logic [3:0] next_w_strb;
	logic next_bvalid;
	logic [1:0] next_bresp;
	logic next_rvalid;
	logic [31:0] next_rdata;
	logic [1:0] next_rresp;

	assign s_axi_awready = !aw_held && !s_axi_bvalid;
	assign s_axi_wready = !w_held && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;

	always_comb
	begin
		next_aw_held = aw_held;
		next_w_held = w_held;
		next_aw_addr = aw_addr;
		next_w_data = w_data;
		next_w_strb = w_strb;
		next_bvalid = s_axi_bvalid;
		next_bresp = s_axi_bresp;
		next_ctrl = ctrl;
		if (s_axi_awvalid && s_axi_awready)
		begin
			next_aw_held = 1'b1;
			next_aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready)
		begin
			next_w_held = 1'b1;
			next_w_data = s_axi_wdata;
			next_w_strb = s_axi_wstrb;
		end
		if (s_axi_bvalid && s_axi_bready)
			next_bvalid = 1'b0;
		if (aw_held && w_held)
		begin
			next_aw_held = 1'b0;
			next_w_held = 1'b0;
			next_bvalid = 1'b1;
			if (aw_addr == DAOC_REG_CTRL)
			begin
				next_bresp = DAOC_RESP_OK;
				if (w_strb[0])
					next_ctrl = w_data[3:0];
			end
			else if (aw_addr == DAOC_REG_STAT || aw_addr == DAOC_REG_SAMP)
				next_bresp = DAOC_RESP_OK;
			else
				next_bresp = DAOC_RESP_DEC;
		end
	end

	always_comb
	begin
		next_rvalid = s_axi_rvalid;
		next_rdata = s_axi_rdata;
		next_rresp = s_axi_rresp;
		if (s_axi_rvalid && s_axi_rready)
			next_rvalid = 1'b0;
		if (s_axi_arvalid && s_axi_arready)
		begin
			next_rvalid = 1'b1;
			next_rresp = DAOC_RESP_OK;
			if (s_axi_araddr == DAOC_REG_CTRL)
				next_rdata = {28'h0000000, ctrl};
			else if (s_axi_araddr == DAOC_REG_STAT)
				next_rdata = {20'h00000, dcs_locked, stabilizer_on, twos_comp, bus_straight,
					valid_b, en_b, pwr_b, valid_a, en_a, pwr_a};
			else if (s_axi_araddr == DAOC_REG_SAMP)
				next_rdata = {3'h0, samp_b.flag, samp_b.word, 3'h0, samp_a.flag, samp_a.word};
			else
			begin
				next_rdata = 32'h00000000;
				next_rresp = DAOC_RESP_DEC;
			end
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			ctrl <= 4'h0;
			clk_a_q <= 1'b0;
			clk_b_q <= 1'b0;
			lock_cnt <= '0;
			bus_a <= '0;
			bus_b <= '0;
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= 32'h00000000;
			w_data <= 32'h00000000;
			w_strb <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'h0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= 2'h0;
		end
		else
		begin
			ctrl <= next_ctrl;
			clk_a_q <= sample_clock_a;
			clk_b_q <= sample_clock_b;
			lock_cnt <= next_lock_cnt;
			bus_a <= next_bus_a;
			bus_b <= next_bus_b;
			aw_held <= next_aw_held;
			w_held <= next_w_held;
			aw_addr <= next_aw_addr;
			w_data <= next_w_data;
			w_strb <= next_w_strb;
			s_axi_bvalid <= next_bvalid;
			s_axi_bresp <= next_bresp;
			s_axi_rvalid <= next_rvalid;
			s_axi_rdata <= next_rdata;
			s_axi_rresp <= next_rresp;
		end
	end
endmodule : daoc_top
`default_nettype wire

/* File: verification/daoc_asserts.sv */
// Checker for the dual converter output control block
`timescale 1ns/100ps
`default_nettype none
module daoc_asserts
	import daoc_pkg::*;
(
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Straps and controls
	input wire logic [1:0] format_select,
	input wire logic bus_swap_select,
	input wire logic output_disable_n_a,
	input wire logic power_down_in_a,
	// Output pins
	input wire logic [11:0] bus_a_data,
	input wire logic [11:0] bus_a_data_oe,
	input wire logic overrange_flag_a,
	input wire logic overrange_flag_a_oe,
	input wire logic [11:0] bus_b_data_oe,
	input wire logic overrange_flag_b_oe,
	input wire logic stabilizer_on,
	// Register bus answers
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [31:0] s_axi_rdata
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// Bus A carries channel A while the select stayed high and ctrl does not force the routing
	sequence straight_s;
		bus_swap_select && $past(bus_swap_select);
	endsequence
	sequence off_a_s;
		$past(output_disable_n_a) ##0 straight_s;
	endsequence
	sequence on_a_s;
		$past(aresetn) && !$past(output_disable_n_a) && !$past(power_down_in_a)
			&& !$past(power_down_in_a, 2) ##0 straight_s;
	endsequence
	sequence down_a_s;
		$past(power_down_in_a) && $past(power_down_in_a, 2) ##0 straight_s;
	endsequence
	float_a_a: assert property (off_a_s |-> bus_a_data_oe == 12'h000)
		else $error("bus a driven while disabled");
	drive_a_a: assert property (on_a_s |-> bus_a_data_oe == 12'hFFF)
		else $error("bus a not driven in normal operation");
	nap_float_a: assert property (down_a_s |-> !overrange_flag_a_oe && bus_a_data_oe == 12'h000)
		else $error("bus a driven while powered down");
	pin_group_a: assert property (bus_a_data_oe == {12{overrange_flag_a_oe}}
		&& bus_b_data_oe == {12{overrange_flag_b_oe}})
		else $error("word and flag enables differ");
	clamp_code_a: assert property (overrange_flag_a
		|-> bus_a_data inside {12'h000, 12'hFFF, 12'h800, 12'h7FF})
		else $error("range flag without end code");
	stab_level_a: assert property (stabilizer_on
		== (format_select inside {DAOC_LVL_THIRD, DAOC_LVL_TWO_THIRD}))
		else $error("stabilizer state wrong for strap level");
	bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped early");
	rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped early");
endmodule : daoc_asserts
`default_nettype wire

/* File: verification/daoc_capture.sv */
// Downstream capture model: sees the pins as the wire carries them
`timescale 1ns/100ps
`default_nettype none
module daoc_capture
	import daoc_pkg::*;
(
	// Clock
	input wire logic aclk,
	// Pins from the converter
	input wire daoc_bus_s side_a,
	input wire daoc_bus_s side_b,
	// Levels seen on the wire
	output daoc_samp_s wire_a,
	output daoc_samp_s wire_b
);
	daoc_samp_s last_a = '0;
	daoc_samp_s last_b = '0;
	// A released bus floats; show a changing pattern so no stale value passes
	always_comb
	begin
		wire_a = side_a.en ? {side_a.data, side_a.flag} : ~last_a;
		wire_b = side_b.en ? {side_b.data, side_b.flag} : ~last_b;
	end
	always_ff @(posedge aclk)
	begin
		last_a <= wire_a;
		last_b <= wire_b;
	end
endmodule : daoc_capture
`default_nettype wire

/* File: verification/daoc_top_tb.sv */
// Self-checking testbench for the dual converter output control block
`timescale 1ns/100ps
`default_nettype none
module daoc_top_tb;
	import daoc_pkg::*;
	logic aclk, aresetn, sample_clock_a, sample_clock_b, over_hi_a, over_lo_a, over_hi_b, over_lo_b;
	logic [11:0] raw_code_a, raw_code_b, bus_a_data, bus_a_data_oe, bus_b_data, bus_b_data_oe;
	logic [1:0] format_select, s_axi_bresp, s_axi_rresp, rr;
	logic bus_swap_select, output_disable_n_a, output_disable_n_b, power_down_in_a, power_down_in_b;
	logic overrange_flag_a, overrange_flag_a_oe, overrange_flag_b, overrange_flag_b_oe, stabilizer_on;
	logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, rd;
	logic [3:0] s_axi_wstrb;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	int fails = 0;
	int n_tests = 0;
	daoc_bus_s side_a, side_b;
	daoc_samp_s wire_a, wire_b;
	assign side_a = {bus_a_data, overrange_flag_a, bus_a_data_oe[0]};
	assign side_b = {bus_b_data, overrange_flag_b, bus_b_data_oe[0]};
	daoc_top #(.WAKE_SLEEP_CYC(20)) uut (.aclk, .aresetn, .sample_clock_a, .sample_clock_b,
		.raw_code_a, .raw_code_b, .over_hi_a, .over_lo_a, .over_hi_b, .over_lo_b, .format_select,
		.bus_swap_select, .output_disable_n_a, .output_disable_n_b, .power_down_in_a,
		.power_down_in_b, .bus_a_data, .bus_a_data_oe, .overrange_flag_a, .overrange_flag_a_oe,
		.bus_b_data, .bus_b_data_oe, .overrange_flag_b, .overrange_flag_b_oe, .stabilizer_on,
		.s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
	daoc_capture cap (.aclk, .side_a, .side_b, .wire_a, .wire_b);
	initial
	begin
		aclk = 0;
		forever #10 aclk = ~aclk;
	end
	task close_out;
		$display("Checks %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : close_out
	task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			fails++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task axi_write(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
		int i;
		logic aw, w;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		s_axi_bready <= 1;
		aw = 1;
		w = 1;
		for (i = 0; i < 50; i++)
		begin
			@(posedge aclk);
			if (!aw && !w && s_axi_bvalid)
				break;
			if (aw && s_axi_awready)
			begin
				aw = 0;
				s_axi_awvalid <= 0;
			end
			if (w && s_axi_wready)
			begin
				w = 0;
				s_axi_wvalid <= 0;
			end
		end
		if (i == 50)
		begin
			fails++;
			close_out;
		end
		check("bresp", s_axi_bresp, er);
		s_axi_bready <= 0;
	endtask : axi_write
	task axi_read(input logic [31:0] a);
		int i;
		logic pend;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		s_axi_rready <= 1;
		pend = 1;
		for (i = 0; i < 50; i++)
		begin
			@(posedge aclk);
			if (!pend && s_axi_rvalid)
				break;
			if (pend && s_axi_arready)
			begin
				pend = 0;
				s_axi_arvalid <= 0;
			end
		end
		if (i == 50)
		begin
			fails++;
			close_out;
		end
		rd = s_axi_rdata;
		rr = s_axi_rresp;
		s_axi_rready <= 0;
	endtask : axi_read
	// One sample on both channels, tied clocks as on a shared bus
	task tick(input logic [11:0] ra, input logic [11:0] rb, input logic hi, input logic lo);
		@(posedge aclk);
		raw_code_a <= ra;
		raw_code_b <= rb;
		over_hi_a <= hi;
		over_hi_b <= hi;
		over_lo_a <= lo;
		over_lo_b <= lo;
		repeat (2) @(posedge aclk);
		sample_clock_a <= 1;
		sample_clock_b <= 1;
		repeat (3) @(posedge aclk);
		sample_clock_a <= 0;
		sample_clock_b <= 0;
		repeat (3) @(posedge aclk);
	endtask : tick
	task t_format;
		int lv, k;
		logic [11:0] c, e, m;
		for (lv = 0; lv < 4; lv++)
		begin
			format_select <= lv[1:0];
			m = {lv[1], 11'h000};
			for (k = 0; k < 5; k++)
			begin
				c = (k == 0) ? 12'h000 : (k == 1) ? 12'h800 : (k == 2) ? 12'hFFF : 12'h123;
				e = (k == 3) ? 12'hFFF : (k == 4) ? 12'h000 : c;
				tick(c, c ^ 12'h555, k == 3, k == 4);
				check("word a", wire_a.word, e ^ m);
				check("word b", wire_b.word, ((k > 2) ? e : c ^ 12'h555) ^ m);
				check("flag a", wire_a.flag, k > 2);
				check("flag b", wire_b.flag, k > 2);
				check("stabilizer", stabilizer_on, lv == 1 || lv == 2);
			end
		end
	endtask : t_format
	task t_swap;
		format_select <= 2'b00;
		bus_swap_select <= 0;
		tick(12'h0AB, 12'h0CD, 0, 0);
		check("swapped a", wire_a.word, 12'h0CD);
		check("swapped b", wire_b.word, 12'h0AB);
		bus_swap_select <= 1;
		tick(12'h0AB, 12'h0CD, 0, 0);
		check("straight a", wire_a.word, 12'h0AB);
		check("straight b", wire_b.word, 12'h0CD);
		// Software override: force two's complement and swapped routing
		axi_write(DAOC_REG_CTRL, 32'h0000_0007, DAOC_RESP_OK);
		tick(12'h0AB, 12'h0CD, 0, 0);
		check("forced a", wire_a.word, 12'h8CD);
		check("forced b", wire_b.word, 12'h8AB);
		axi_write(DAOC_REG_CTRL, 32'h0000_0000, DAOC_RESP_OK);
	endtask : t_swap
	// Shared bus: select follows both sample clocks, so bus A alternates channels
	task t_mux;
		@(posedge aclk);
		raw_code_a <= 12'h3C5;
		raw_code_b <= 12'h5A3;
		repeat (2) @(posedge aclk);
		{sample_clock_a, sample_clock_b, bus_swap_select} <= 3'h7;
		repeat (3) @(posedge aclk);
		check("mux high a", wire_a.word, 12'h3C5);
		{sample_clock_a, sample_clock_b, bus_swap_select} <= 3'h0;
		repeat (3) @(posedge aclk);
		check("mux low a", wire_a.word, 12'h5A3);
		check("mux low b", wire_b.word, 12'h3C5);
		bus_swap_select <= 1;
	endtask : t_mux
	task t_oe;
		// Disable changes only between bursts, never at full rate
		output_disable_n_a <= 1;
		tick(12'h321, 12'h456, 0, 0);
		check("oe a", {bus_a_data_oe, overrange_flag_a_oe}, 13'h0000);
		check("oe b", bus_b_data_oe, 12'hFFF);
		check("word b", wire_b.word, 12'h456);
		output_disable_n_a <= 0;
		tick(12'h321, 12'h456, 0, 0);
		check("word a", wire_a.word, 12'h321);
	endtask : t_oe
	task t_power;
		power_down_in_a <= 1;
		tick(12'h111, 12'h222, 0, 0);
		check("oe nap", bus_a_data_oe, 12'h000);
		check("word b", wire_b.word, 12'h222);
		axi_read(DAOC_REG_STAT);
		check("pwr a", rd[1:0], DAOC_PWR_NAP);
		check("pwr b", rd[5:4], DAOC_PWR_RUN);
		power_down_in_a <= 0;
		repeat (50) @(posedge aclk);
		axi_read(DAOC_REG_STAT);
		check("nap wake", rd[1:0], DAOC_PWR_WAKE);
		repeat (60) @(posedge aclk);
		axi_read(DAOC_REG_STAT);
		check("nap done", rd[1:0], DAOC_PWR_RUN);
		output_disable_n_a <= 1;
		power_down_in_a <= 1;
		repeat (3) @(posedge aclk);
		axi_read(DAOC_REG_STAT);
		check("sleep", rd[1:0], DAOC_PWR_SLEEP);
		power_down_in_a <= 0;
		axi_read(DAOC_REG_STAT);
		check("sleep wake", rd[1:0], DAOC_PWR_WAKE);
		repeat (30) @(posedge aclk);
		axi_read(DAOC_REG_STAT);
		check("sleep done", rd[1:0], DAOC_PWR_RUN);
		output_disable_n_a <= 0;
	endtask : t_power
	task t_axi;
		axi_write(DAOC_REG_CTRL, 32'h0000_000A, DAOC_RESP_OK);
		axi_read(DAOC_REG_CTRL);
		check("ctrl", rd[3:0], 4'hA);
		check("ctrl resp", rr, DAOC_RESP_OK);
		axi_write(DAOC_REG_STAT, 32'hFFFF_FFFF, DAOC_RESP_OK);
		axi_write(32'h0000_0010, 32'h0000_0001, DAOC_RESP_DEC);
		axi_read(32'h0000_000C);
		check("unmapped resp", rr, DAOC_RESP_DEC);
		check("unmapped data", rd, 32'h0000_0000);
		axi_write(DAOC_REG_CTRL, 32'h0000_0000, DAOC_RESP_OK);
	endtask : t_axi
	initial
	begin
		{aresetn, sample_clock_a, sample_clock_b, over_hi_a, over_lo_a, over_hi_b, over_lo_b} = '0;
		{raw_code_a, raw_code_b, format_select, output_disable_n_a, output_disable_n_b} = '0;
		{power_down_in_a, power_down_in_b, s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		s_axi_wstrb = 4'hF;
		bus_swap_select = 1;
		repeat (5) @(posedge aclk);
		aresetn <= 1;
		t_axi;
		t_format;
		t_swap;
		t_mux;
		t_oe;
		t_power;
		close_out;
	end
endmodule : daoc_top_tb
bind daoc_top daoc_asserts chk (.aclk, .aresetn, .format_select, .bus_swap_select,
	.output_disable_n_a, .power_down_in_a, .bus_a_data, .bus_a_data_oe, .overrange_flag_a,
	.overrange_flag_a_oe, .bus_b_data_oe, .overrange_flag_b_oe, .stabilizer_on, .s_axi_bvalid,
	.s_axi_bready, .s_axi_bresp, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata);
`default_nettype wire
